/* rtl/tc_cfg_pkg.sv */
package tc_cfg_pkg;

    // ------------------------------------------------------------
    // Selector encodings
    // ------------------------------------------------------------
    localparam logic [3:0] SENSOR_DEFAULT = 4'h2;
    localparam logic [3:0] ALARM_DEFAULT = 4'h2;
    localparam logic [3:0] SEL_MAX = 4'h9;

    localparam logic [3:0] ALM_OFF = 4'h0;
    localparam logic [3:0] ALM_UPLO = 4'h1;
    localparam logic [3:0] ALM_UPPER = 4'h2;
    localparam logic [3:0] ALM_LOWER = 4'h3;
    localparam logic [3:0] ALM_RANGE = 4'h4;
    localparam logic [3:0] ALM_SB_UPLO = 4'h5;
    localparam logic [3:0] ALM_SB_UPPER = 4'h6;
    localparam logic [3:0] ALM_SB_LOWER = 4'h7;
    localparam logic [3:0] ALM_EVENT = 4'h8;
    localparam logic [3:0] ALM_PROP = 4'h9;

    // ------------------------------------------------------------
    // Function switch pin positions (pin n at bit n-1)
    // ------------------------------------------------------------
    localparam int PIN_ONOFF = 0;
    localparam int PIN_NORMAL = 1;
    localparam int PIN_SHIFT = 2;
    localparam int PIN_RSVD = 3;
    localparam int PIN_FAHR = 4;
    localparam int PIN_PIDDISP = 5;

    // ------------------------------------------------------------
    // Temperatures in tenths of a degree, signed 16 bit
    // ------------------------------------------------------------
    localparam int TEMP_W = 16;
    localparam logic signed [15:0] PROP_BAND = 16'sh01a4;
    localparam int PROP_PERIOD_S = 20;
    localparam int CLK_HZ = 100000000;
    localparam longint PROP_PERIOD_CYC = longint'(PROP_PERIOD_S) * longint'(CLK_HZ);

    // Range table, Celsius, tenths of a degree, indexed by sensor type
    localparam logic signed [15:0] RANGE_LO [10] = '{
        16'sh0000, 16'sh0000, -16'sh07d0, -16'sh03e8, -16'sh07d0,
        16'sh0000, -16'sh03e7, -16'sh03e7, -16'sh03e8, -16'sh07d0};
    localparam logic signed [15:0] RANGE_HI [10] = '{
        16'sh4268, 16'sh4268, 16'sh32c8, 16'sh2134, 16'sh0fa0,
        16'sh1770, 16'sh1194, 16'sh1194, 16'sh2134, 16'sh0fa0};

endpackage

/* rtl/tc_prop_pwm.sv */
`timescale 1ns/10ps
`default_nettype none

// Time-proportioning output: on-time within the period is excess/band.
module tc_prop_pwm #(
    parameter longint PERIOD_CYC = 64'd2000000000,
    parameter int W = 32
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [15:0] i_excess,
    input wire logic [15:0] i_band,
    output logic o_on
);
    logic [W-1:0] count;
    logic [W-1:0] threshold;
    logic [W+15:0] prod;

    assign prod = (W+16)'(PERIOD_CYC) * (W+16)'(i_excess);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            count <= '0;
        end else if (count == W'(PERIOD_CYC - 1)) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    // Duty latched once a period so the pulse is not chopped mid-cycle
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            threshold <= '0;
        end else if (count == '0) begin
            threshold <= (i_band == 16'h0000) ? '0 : W'(prod / (W+16)'(i_band));
        end
    end

    // Band edges act at once; only the duty inside the band waits for a new period,
    // otherwise a full-on alarm could lag by up to one whole period
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_on <= 1'b0;
        end else if (i_excess == 16'h0000) begin
            o_on <= 1'b0;
        end else if (i_excess >= i_band) begin
            o_on <= 1'b1;
        end else begin
            o_on <= (count < threshold);
        end
    end
endmodule

`default_nettype wire

/* rtl/tc_cfg_alarm.sv */
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Ten sensor selector positions decode to ten sensor types with ranges.
// - Sensor selector default position 2, K thermocouple.
// - Function pins set control type, direction, shift, scale, tuning display.
// - Alarm selector picks one of ten alarm modes.
// - Alarm selector default position 2, upper-limit alarm.
// - Proportional alarm starts at the alarm point, band lower edge.
// - Proportional alarm fully on at band upper edge.
// - Proportional band fixed 42 C, period fixed 20 s.
// - Alarm evaluation ignores output direction pin.
// - Standby modes hold alarm off until limit exceeded once.
// - Write lock ignores level, up, down and auto-tune keys.
// - Write lock still allows viewing set values, blocks changes.
// - Alarm output and alarm lamp driven together.
// - Alarm value is deviation in limit modes, absolute in event mode.
module tc_cfg_alarm (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [3:0] i_sensor_type_selector,
    input wire logic [5:0] i_function_option_switch,
    input wire logic [3:0] i_alarm_type_selector,
    input wire logic i_write_lock_switch,
    input wire logic i_key_level,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_autotune,
    input wire logic i_key_display,
    input wire logic signed [15:0] i_temp,
    input wire logic signed [15:0] i_set_point,
    input wire logic signed [15:0] i_alarm_value,
    output logic [3:0] o_sensor_type,
    output logic signed [15:0] o_range_lo,
    output logic signed [15:0] o_range_hi,
    output logic o_onoff_control,
    output logic o_normal_output,
    output logic o_input_shift_en,
    output logic o_fahrenheit,
    output logic o_pid_display_en,
    output logic [3:0] o_alarm_mode,
    output logic o_alarm_value_visible,
    output logic o_key_level,
    output logic o_key_up,
    output logic o_key_down,
    output logic o_key_autotune,
    output logic o_key_display,
    output logic o_alarm_out,
    output logic o_alarm_lamp
);
    // ------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_WAIT = 2'b01,
        CAP_HELD = 2'b10
    } cap_state_e;

    cap_state_e cap_state;
    logic [3:0] sensor;
    logic [3:0] mode;
    logic [5:0] func;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cap_state <= CAP_WAIT;
        end else begin
            case (cap_state)
                CAP_WAIT: cap_state <= CAP_HELD;
                CAP_HELD: cap_state <= CAP_HELD;
                default: cap_state <= CAP_WAIT;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sensor <= tc_cfg_pkg::SENSOR_DEFAULT;
            mode <= tc_cfg_pkg::ALARM_DEFAULT;
            func <= '0;
        end else if (cap_state == CAP_WAIT) begin
            // out-of-range codes fall back to the default
            sensor <= (i_sensor_type_selector > tc_cfg_pkg::SEL_MAX) ?
                tc_cfg_pkg::SENSOR_DEFAULT : i_sensor_type_selector;
            mode <= (i_alarm_type_selector > tc_cfg_pkg::SEL_MAX) ?
                tc_cfg_pkg::ALARM_DEFAULT : i_alarm_type_selector;
            // pin 4 is not used by any logic
            func <= i_function_option_switch;
        end
    end

    // ------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------
    // range lookup (Celsius, tenths of a degree)
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_range_lo <= tc_cfg_pkg::RANGE_LO[tc_cfg_pkg::SENSOR_DEFAULT];
            o_range_hi <= tc_cfg_pkg::RANGE_HI[tc_cfg_pkg::SENSOR_DEFAULT];
        end else begin
            o_range_lo <= tc_cfg_pkg::RANGE_LO[sensor];
            o_range_hi <= tc_cfg_pkg::RANGE_HI[sensor];
        end
    end

    // default position 2 through reset value
    assign o_sensor_type = sensor;
    assign o_onoff_control = func[tc_cfg_pkg::PIN_ONOFF];
    assign o_normal_output = func[tc_cfg_pkg::PIN_NORMAL];
    assign o_input_shift_en = func[tc_cfg_pkg::PIN_SHIFT];
    assign o_fahrenheit = func[tc_cfg_pkg::PIN_FAHR];
    assign o_pid_display_en = func[tc_cfg_pkg::PIN_PIDDISP] & ~func[tc_cfg_pkg::PIN_ONOFF];
    // default mode 2 through reset value
    assign o_alarm_mode = mode;
    // alarm value hidden in mode 0
    assign o_alarm_value_visible = (mode != tc_cfg_pkg::ALM_OFF);

    // ------------------------------------------------------------
    // Key gating
    // ------------------------------------------------------------
    // lock blocks changing keys
    assign o_key_level = i_key_level & ~i_write_lock_switch;
    assign o_key_up = i_key_up & ~i_write_lock_switch;
    assign o_key_down = i_key_down & ~i_write_lock_switch;
    assign o_key_autotune = i_key_autotune & ~i_write_lock_switch;
    // display key still steps through values for viewing
    assign o_key_display = i_key_display;

    // ------------------------------------------------------------
    // Alarm evaluation
    // ------------------------------------------------------------
    logic signed [17:0] dev;
    logic signed [17:0] xval;
    logic signed [17:0] prop_excess;
    logic upper_hit;
    logic lower_hit;
    logic band_out;
    logic raw;
    logic armed;
    logic prop_on;
    logic standby_mode;

    // deviation in limit modes, absolute in event mode
    assign dev = 18'(i_temp) - 18'(i_set_point);
    assign xval = 18'(i_alarm_value);
    assign upper_hit = dev >= xval;
    assign lower_hit = dev <= -xval;
    assign band_out = upper_hit | lower_hit;
    assign standby_mode = (mode == tc_cfg_pkg::ALM_SB_UPLO) ||
        (mode == tc_cfg_pkg::ALM_SB_UPPER) || (mode == tc_cfg_pkg::ALM_SB_LOWER);
    // excess above the alarm point measured in the band
    assign prop_excess = 18'(i_temp) - 18'(i_alarm_value);

    // direction pin never enters the evaluation
    always_comb begin
        case (mode)
            tc_cfg_pkg::ALM_UPLO: raw = band_out;
            tc_cfg_pkg::ALM_UPPER: raw = upper_hit;
            tc_cfg_pkg::ALM_LOWER: raw = lower_hit;
            tc_cfg_pkg::ALM_RANGE: raw = ~band_out;
            tc_cfg_pkg::ALM_SB_UPLO: raw = band_out;
            tc_cfg_pkg::ALM_SB_UPPER: raw = upper_hit;
            tc_cfg_pkg::ALM_SB_LOWER: raw = lower_hit;
            tc_cfg_pkg::ALM_EVENT: raw = (i_temp >= i_alarm_value);
            tc_cfg_pkg::ALM_PROP: raw = prop_on;
            default: raw = 1'b0;
        endcase
    end

    // arm once the limit has been crossed
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            armed <= 1'b0;
        end else if (standby_mode && raw) begin
            armed <= 1'b1;
        end
    end

    tc_prop_pwm #(
        .PERIOD_CYC(tc_cfg_pkg::PROP_PERIOD_CYC),
        .W(32)
    ) u_pwm (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_excess(
            (prop_excess <= 0) ? 16'h0000 :
            (prop_excess >= 18'(tc_cfg_pkg::PROP_BAND)) ? tc_cfg_pkg::PROP_BAND :
            prop_excess[15:0]),
        .i_band(tc_cfg_pkg::PROP_BAND),
        .o_on(prop_on)
    );

    // output and lamp from one flop
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_alarm_out <= 1'b0;
        end else if (cap_state != CAP_HELD) begin
            o_alarm_out <= 1'b0;
        end else begin
            // mode 0 gives raw of zero; standby gating below
            o_alarm_out <= raw & (~standby_mode | armed);
        end
    end
    assign o_alarm_lamp = o_alarm_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_lamp_follows: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_alarm_lamp == o_alarm_out) else $error("lamp differs from alarm");
    chk_mode_off_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
        (mode == tc_cfg_pkg::ALM_OFF) |=> !o_alarm_out) else $error("alarm in mode 0");
    chk_lock_keys: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_write_lock_switch |-> !(o_key_level | o_key_up | o_key_down | o_key_autotune))
        else $error("key passed while locked");
    chk_config_held: assert property (@(posedge i_mclk) disable iff (i_reset)
        (cap_state == CAP_HELD) |=> $stable(mode) && $stable(sensor) && $stable(func))
        else $error("config changed after capture");
    chk_standby_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
        (standby_mode && !armed) |=> !o_alarm_out) else $error("alarm before arming");
    chk_upper_alarm: assert property (@(posedge i_mclk) disable iff (i_reset)
        (cap_state == CAP_HELD && mode == tc_cfg_pkg::ALM_UPPER) |=>
        (o_alarm_out == $past(upper_hit))) else $error("upper alarm wrong");
    chk_view_locked: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_key_display |-> o_key_display) else $error("view blocked");
    chk_sensor_range: assert property (@(posedge i_mclk) disable iff (i_reset)
        sensor <= tc_cfg_pkg::SEL_MAX) else $error("sensor out of range");

endmodule

`default_nettype wire

/* bench/tc_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Front panel and internal switches as the operator sets them, with function pin 4 always driven low
module tc_panel_model (
    input wire logic [5:0] i_func_req,
    input wire logic [4:0] i_keys_req,
    output logic [5:0] o_function_option_switch,
    output logic [4:0] o_keys
);
    assign o_function_option_switch = i_func_req & 6'h37;
    assign o_keys = i_keys_req;
endmodule

`default_nettype wire

/* bench/temp_ctrl_switch_config_alarm_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module temp_ctrl_switch_config_alarm_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] sensor = 4'h0;
    logic [3:0] alarm_sel = 4'h0;
    logic [5:0] func_req = 6'h00;
    logic [5:0] func;
    logic lock = 1'b0;
    logic [4:0] keys_req = 5'h00;
    logic [4:0] keys;
    logic signed [15:0] temp = 16'sh0000;
    logic signed [15:0] sp = 16'sh0000;
    logic signed [15:0] av = 16'sh0000;
    logic [3:0] sensor_type, alarm_mode;
    logic signed [15:0] range_lo, range_hi;
    logic onoff, normal, shift, fahr, piddisp, visible;
    logic k_level, k_up, k_down, k_at, k_disp, alarm, lamp;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;

    tc_panel_model panel (
        .i_func_req(func_req),
        .i_keys_req(keys_req),
        .o_function_option_switch(func),
        .o_keys(keys)
    );

    tc_cfg_alarm dut (
        .i_mclk(mclk),
        .i_reset(reset),
        .i_sensor_type_selector(sensor),
        .i_function_option_switch(func),
        .i_alarm_type_selector(alarm_sel),
        .i_write_lock_switch(lock),
        .i_key_level(keys[0]),
        .i_key_up(keys[1]),
        .i_key_down(keys[2]),
        .i_key_autotune(keys[3]),
        .i_key_display(keys[4]),
        .i_temp(temp),
        .i_set_point(sp),
        .i_alarm_value(av),
        .o_sensor_type(sensor_type),
        .o_range_lo(range_lo),
        .o_range_hi(range_hi),
        .o_onoff_control(onoff),
        .o_normal_output(normal),
        .o_input_shift_en(shift),
        .o_fahrenheit(fahr),
        .o_pid_display_en(piddisp),
        .o_alarm_mode(alarm_mode),
        .o_alarm_value_visible(visible),
        .o_key_level(k_level),
        .o_key_up(k_up),
        .o_key_down(k_down),
        .o_key_autotune(k_at),
        .o_key_display(k_disp),
        .o_alarm_out(alarm),
        .o_alarm_lamp(lamp)
    );

    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Generous ceiling: the whole run needs about 600 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic exp_alarm(input logic [3:0] m, input int t, input int s,
                                       input int a);
        case (m)
            4'h1, 4'h5: return ((t - s) >= a) || ((t - s) <= -a);
            4'h2, 4'h6: return (t - s) >= a;
            4'h3, 4'h7: return (t - s) <= -a;
            4'h4: return ((t - s) < a) && ((t - s) > -a);
            4'h8: return t >= a;
            default: return 1'b0;
        endcase
    endfunction

    task automatic power_up(input logic [3:0] s, input logic [3:0] a, input logic [5:0] f);
        reset = 1'b1;
        sensor = s;
        alarm_sel = a;
        func_req = f;
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    task automatic check_cfg(input logic [3:0] s, input logic [3:0] a, input logic [5:0] f);
        check_val(16'(sensor_type), 16'(s));
        check_val(range_lo, tc_cfg_pkg::RANGE_LO[s]);
        check_val(range_hi, tc_cfg_pkg::RANGE_HI[s]);
        check_val({12'h000, onoff, normal, shift, fahr}, {12'h000, f[0], f[1], f[2], f[4]});
        check_val(16'(piddisp), 16'(f[5] & ~f[0]));
        check_val(16'(alarm_mode), 16'(a));
        check_val(16'(visible), 16'(a != 4'h0));
    endtask

    initial begin
        logic [3:0] s;
        logic [5:0] f;
        int t;
        logic hit;
        logic armed_exp;
        void'($urandom(32'h97c1));
        repeat (10) @(negedge mclk);
        check_val(16'(sensor_type), 16'(tc_cfg_pkg::SENSOR_DEFAULT));
        check_val(16'(alarm_mode), 16'(tc_cfg_pkg::ALARM_DEFAULT));
        check_val(16'({alarm, lamp}), 16'h0000);
        for (int m = 0; m < 10; m++) begin
            s = (m == 2) ? 4'h2 : 4'($urandom % 10);
            f = 6'($urandom);
            // Quiet inputs so no standby mode arms before its scenario starts
            temp = 16'sh0000;
            sp = 16'sh0000;
            av = 16'sh0001;
            power_up(s, 4'(m), f);
            check_cfg(s, 4'(m), f & 6'h37);
            // Switches moved after power-up must not reach the outputs
            sensor = 4'($urandom % 10);
            alarm_sel = 4'($urandom % 10);
            func_req = ~func_req;
            repeat (3) @(negedge mclk);
            check_cfg(s, 4'(m), f & 6'h37);
            for (int i = 0; i < 8; i++) begin
                lock = i[0];
                keys_req = 5'($urandom);
                @(negedge mclk);
                check_val(16'({k_disp, k_at, k_down, k_up, k_level}),
                          16'({keys[4], keys[3:0] & {4{~lock}}}));
                check_val(16'(visible), 16'(m != 0));
            end
            lock = 1'b0;
            if (m != 9) begin
                // Standby modes: the first hit is held off, later hits show
                armed_exp = 1'b0;
                for (int i = 0; i < 30; i++) begin
                    sp = 16'($urandom_range(400) - 200);
                    av = 16'($urandom_range(600));
                    t = (i == 0) ? sp + av : int'($urandom_range(1400)) - 400;
                    temp = 16'(t);
                    @(negedge mclk);
                    hit = exp_alarm(4'(m), t, sp, av);
                    check_val(16'(alarm), 16'(hit & (armed_exp | (m < 5) | (m > 7))));
                    check_val(16'(lamp), 16'(alarm));
                    armed_exp = armed_exp | hit;
                end
            end
            if (m == 9) begin
                sp = 16'sh0000;
                av = 16'sh03e8;
                temp = 16'sh0384;
                for (int i = 0; i < 40; i++) begin
                    @(negedge mclk);
                    check_val(16'(alarm), 16'h0000);
                end
                // Band top is the alarm point plus the fixed band
                temp = av + tc_cfg_pkg::PROP_BAND;
                repeat (3) @(negedge mclk);
                for (int i = 0; i < 40; i++) begin
                    @(negedge mclk);
                    check_val(16'(alarm), 16'h0001);
                end
            end
        end
        close_out();
    end
endmodule

`default_nettype wire
